// ### hdl/out_drv_pkg.sv
// Purpose: shared constants and types for the output driver serial control block
// Assumes: 16-bit control word, msb first
// Notes:   field positions and reset value of the control word
package out_drv_pkg;
  localparam int         WORD_BITS     = 16;
  localparam int         ADDR_HI       = 15;
  localparam int         ADDR_LO       = 13;
  localparam int         RW_POS        = 12;
  localparam int         RANGE_HI      = 10;
  localparam int         RANGE_LO      = 7;
  localparam int         CLEAR_LEVEL_SELECT_POS    = 6;
  localparam int         OUTPUT_ENABLE_CTL_POS     = 5;
  localparam int         CLEAR_POS     = 4;
  localparam int         RSEL_POS      = 3;
  localparam int         RESET_POS     = 2;
  localparam logic [4:0] BIT_CNT_LAST  = 5'h10;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;

  // decoded control fields
  typedef struct packed {
    logic [3:0] range_code;
    logic       clear_level_select;
    logic       output_enable_ctl;
    logic       clear_ctl;
    logic       sense_resistor_select;
  } ctrl_fields_t;

  // receiver states, gray coded
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } rx_state_t;
endpackage : out_drv_pkg

// ### hdl/output_driver_serial_ctrl.sv
// Purpose: serial control word receiver and output gating of the output driver
// Assumes: sclk, sdin, sync_n and all pins are asynchronous and sampled by clk
// Notes:   sync_n low frames a word; analog stages lie outside this block
// Summary of operation
// - software mode resets on reset pin low or control write with reset bit set.
// - any reset returns both output channels to disabled power-on state.
// - reset pin is level sensitive; held in reset while low.
// - reset bit returns to zero after a reset command.
// - hardware mode has no reset; system holds reset pin high.
// - software mode: output enable bit gates outputs; cleared means tristate.
// - hardware mode: output enable pin gates outputs instead of register bit.
// - mode pin tied low selects software mode.
// - each transfer is one 16-bit word, msb first.
// - data bits sampled on serial clock falling edge.
// - top three word bits carry board address.
// - word acted on only when address bits match address pins.
// - range 10..7, clear select 6, enable 5, clear 4, resistor 3, reset 2.
// - bit 12 selects read or write.
// - range code with resistor select chooses output configuration.
// - power-on loads all registers but the pin synchronisers with zeros, output disabled.
`timescale 1ns/10ps
module output_driver_serial_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     sdin,
  input  wire logic                     sync_n,
  input  wire logic                     reset_pin_n,
  input  wire logic                     interface_mode_pin,
  input  wire logic                     hw_output_enable_pin,
  input  wire logic                     board_addr_pin2,
  input  wire logic                     board_addr_pin1,
  input  wire logic                     board_addr_pin0,
  output logic [15:0]                   output_control_word,
  output out_drv_pkg::ctrl_fields_t     ctrl_fields,
  output logic                          current_out_en,
  output logic                          voltage_out_en,
  output logic                          in_reset
);
  import out_drv_pkg::*;

  // two-flop synchronisers for every pin
  // reset values are idle levels, so no false serial clock edge follows reset
  logic [8:0] meta_ff;
  logic [8:0] sync_ff;
  logic [8:0] nxt_meta;
  logic [8:0] nxt_sync;
  logic       sclk_prev_ff;
  logic       nxt_sclk_prev;

  always_comb begin
    nxt_meta = {sclk, sdin, sync_n, reset_pin_n, interface_mode_pin, hw_output_enable_pin,
                board_addr_pin2, board_addr_pin1, board_addr_pin0};
    nxt_sync = meta_ff;
    nxt_sclk_prev = sync_ff[8];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff      <= 9'h1f0;
      sync_ff      <= 9'h1f0;
      sclk_prev_ff <= 1'b1;
    end else begin
      meta_ff      <= nxt_meta;
      sync_ff      <= nxt_sync;
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end

  logic       s_sclk;
  logic       s_sdin;
  logic       s_sync_n;
  logic       s_reset_n;
  logic       s_hw_mode;
  logic       s_hw_oe;
  logic [2:0] s_addr;
  logic       sclk_fall;

  // synchronised pin levels and the serial clock falling edge
  assign s_sclk    = sync_ff[8];
  assign s_sdin    = sync_ff[7];
  assign s_sync_n  = sync_ff[6];
  assign s_reset_n = sync_ff[5];
  assign s_hw_mode = sync_ff[4];
  assign s_hw_oe   = sync_ff[3];
  assign s_addr    = sync_ff[2:0];
  assign sclk_fall = sclk_prev_ff & ~s_sclk;

  // word receiver: shift on falling sclk while framed
  rx_state_t  state_ff;
  rx_state_t  nxt_state;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 5'h00;
        if (!s_sync_n) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (s_sync_n) begin
          nxt_state = ST_IDLE;
        end else if (sclk_fall) begin
          nxt_shift = {shift_ff[14:0], s_sdin};
          nxt_cnt   = cnt_ff + 5'h01;
          if (cnt_ff + 5'h01 == BIT_CNT_LAST) begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // bits after the sixteenth are dropped until the frame closes
        if (s_sync_n) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= 16'h0000;
      cnt_ff   <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
    end
  end

  // a word is complete on the transition into done
  logic word_done;
  logic addr_match;
  logic sw_mode;
  logic is_write;

  assign word_done  = (state_ff == ST_SHIFT) && (nxt_state == ST_DONE);
  assign addr_match = (nxt_shift[ADDR_HI:ADDR_LO] == s_addr);
  assign sw_mode    = ~s_hw_mode;
  assign is_write   = ~nxt_shift[RW_POS];

  // control register with self-clearing reset bit
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic        pin_reset;
  logic        bit_reset;

  assign pin_reset = sw_mode & ~s_reset_n;
  assign bit_reset = sw_mode & ctrl_ff[RESET_POS];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    // a reset in the same cycle as a write wins
    if (pin_reset || bit_reset) begin
      nxt_ctrl = CTRL_RESET;
    end else if (word_done && addr_match && is_write && sw_mode) begin
      nxt_ctrl = nxt_shift;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // output gating and registered status
  ctrl_fields_t nxt_fields;
  logic         nxt_oe;
  logic         nxt_in_reset;
  logic         reset_cmd;

  // a stored reset command keeps both channels off in the cycle before it clears
  assign reset_cmd = nxt_ctrl[RESET_POS];

  always_comb begin
    nxt_fields.range_code            = nxt_ctrl[RANGE_HI:RANGE_LO];
    nxt_fields.clear_level_select    = nxt_ctrl[CLEAR_LEVEL_SELECT_POS];
    nxt_fields.output_enable_ctl     = nxt_ctrl[OUTPUT_ENABLE_CTL_POS];
    nxt_fields.clear_ctl             = nxt_ctrl[CLEAR_POS];
    nxt_fields.sense_resistor_select = nxt_ctrl[RSEL_POS];
    nxt_in_reset = pin_reset | bit_reset;
    if (sw_mode) begin
      nxt_oe = nxt_ctrl[OUTPUT_ENABLE_CTL_POS] & ~nxt_in_reset & ~reset_cmd;
    end else begin
      nxt_oe = s_hw_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_control_word <= CTRL_RESET;
      ctrl_fields         <= '0;
      current_out_en      <= 1'b0;
      voltage_out_en      <= 1'b0;
      in_reset            <= 1'b0;
    end else begin
      output_control_word <= nxt_ctrl;
      ctrl_fields         <= nxt_fields;
      current_out_en      <= nxt_oe;
      voltage_out_en      <= nxt_oe;
      in_reset            <= nxt_in_reset;
    end
  end
endmodule : output_driver_serial_ctrl

// ### bench/output_driver_serial_ctrl_chk.sv
// Purpose: port assertions of the serial control block
// Assumes: one clk domain, synchronous rst
// Notes:   bound to the design top
`timescale 1ns/10ps
module output_driver_serial_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reset_pin_n,
  input wire logic        interface_mode_pin,
  input wire logic        hw_output_enable_pin,
  input wire logic [15:0] output_control_word,
  input wire logic        current_out_en,
  input wire logic        voltage_out_en,
  input wire logic        in_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // reset paths and output gating
  property p_por; $fell(rst) |-> output_control_word == 16'h0000; endproperty
  a_por: assert property (p_por) else $error("word not clear");
  property p_off; in_reset |-> !current_out_en && !voltage_out_en; endproperty
  a_off: assert property (p_off) else $error("on in reset");
  property p_pair; current_out_en == voltage_out_en; endproperty
  a_pair: assert property (p_pair) else $error("channels differ");
  property p_pin; (!reset_pin_n && !interface_mode_pin)[*5] |-> in_reset && output_control_word == 16'h0000; endproperty
  a_pin: assert property (p_pin) else $error("pin reset lost");
  property p_self; output_control_word[2] |=> output_control_word == 16'h0000 && in_reset; endproperty
  a_self: assert property (p_self) else $error("reset bit kept");
  property p_sw; (!interface_mode_pin)[*4] ##0 !in_reset && !output_control_word[2] |-> current_out_en == output_control_word[5]; endproperty
  a_sw: assert property (p_sw) else $error("enable bit ignored");
  property p_hw; (interface_mode_pin && $stable(hw_output_enable_pin))[*5] |-> current_out_en == hw_output_enable_pin; endproperty
  a_hw: assert property (p_hw) else $error("enable pin ignored");
  property p_hold; interface_mode_pin[*5] |=> $stable(output_control_word) && !in_reset; endproperty
  a_hold: assert property (p_hold) else $error("hw mode changed");
  property p_rcmd; output_control_word[2] |-> !current_out_en && !voltage_out_en; endproperty
  a_rcmd: assert property (p_rcmd) else $error("on with reset bit");
endmodule : output_driver_serial_ctrl_chk
bind output_driver_serial_ctrl output_driver_serial_ctrl_chk u_chk (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
  .interface_mode_pin(interface_mode_pin), .hw_output_enable_pin(hw_output_enable_pin),
  .output_control_word(output_control_word), .current_out_en(current_out_en), .voltage_out_en(voltage_out_en),
  .in_reset(in_reset));

// ### bench/host_spi_model.sv
// Purpose: host serial master model
// Assumes: serial clock period 8 clk
// Notes:   sclk idles high, still between frames
`timescale 1ns/10ps
module host_spi_model (
  input  wire logic clk,
  output logic      sclk   = 1'b1,
  output logic      sdin   = 1'b0,
  output logic      sync_n = 1'b1
);
  // n bits msb first, set on rise, taken on fall
  task automatic send(input logic [15:0] w, input int n);
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i > 15 - n; i--) begin
      sdin <= w[i];
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    sdin   <= ~sdin; // no stale bit after release
    sync_n <= 1'b1;
    sclk   <= 1'b1; // idle high between frames
    repeat (8) @(posedge clk);
  endtask : send
endmodule : host_spi_model

// ### bench/output_driver_serial_ctrl_bench.sv
// Purpose: self-checking bench of the serial control block
// Assumes: 50 MHz clk
// Notes:   random words plus corner frames
`timescale 1ns/10ps
module output_driver_serial_ctrl_bench;
  import out_drv_pkg::*;
  logic         clk = 0, rst = 1, rp_n = 1, mode = 0, hwen = 0;
  logic [2:0]   addr = 3'h0;
  logic         sclk, sdin, sync_n, ce, ve, ir;
  logic [15:0]  ocw, w, nw;
  ctrl_fields_t cf;
  int           failures = 0, check_count = 0;
  always #10 clk = ~clk;
  host_spi_model u_host (.clk(clk), .sclk(sclk), .sdin(sdin), .sync_n(sync_n));
  output_driver_serial_ctrl dut (.clk(clk), .rst(rst), .sclk(sclk), .sdin(sdin), .sync_n(sync_n),
    .reset_pin_n(rp_n), .interface_mode_pin(mode), .hw_output_enable_pin(hwen), .board_addr_pin2(addr[2]),
    .board_addr_pin1(addr[1]), .board_addr_pin0(addr[0]), .output_control_word(ocw), .ctrl_fields(cf),
    .current_out_en(ce), .voltage_out_en(ve), .in_reset(ir));
  // legal write: rw 0, zero bits and reset bit clear
  function automatic logic [15:0] mk(input logic [2:0] a, input logic [15:0] r);
    return {a, r[12:0] & 13'h07f8};
  endfunction : mk
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // watchdog
  initial begin
    #300000;
    failures++;
    close_out();
  end
  // main sequence
  initial begin
    void'($urandom(32'h6f99));
    repeat (4) @(posedge clk);
    rst  <= 0;
    addr <= 3'($urandom);
    repeat (4) @(posedge clk);
    chk(ocw, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      nw = (i == 0) ? {addr, 13'h0020} : mk(addr, 16'($urandom));
      if (i > 0 && w[5] && nw[10:7] != w[10:7]) begin
        u_host.send(w & 16'hffdf, 16);
        chk({ce, ve}, 2'b00);
      end
      w = nw;
      u_host.send(w, 16);
      chk(ocw, w);
      chk({8'h00, cf}, {8'h00, w[10:3]});
      chk({ce, ve}, {2{w[5]}});
    end
    u_host.send(mk(addr ^ 3'h5, 16'h0020), 16);
    chk(ocw, w);
    u_host.send(w ^ 16'h1020, 16);
    chk(ocw, w);
    u_host.send(w ^ 16'h0020, 12);
    chk(ocw, w);
    u_host.send(w | 16'h0024, 16);
    chk({ocw[15:1], ce}, 16'h0000);
    u_host.send(w | 16'h0020, 16);
    chk(ocw, w | 16'h0020);
    rp_n <= 0;
    repeat (8) @(posedge clk);
    u_host.send(w | 16'h0020, 16);
    chk({ocw[15:1], ce} ^ ir, 16'h0001);
    rp_n <= 1;
    mode <= 1;
    hwen <= 1;
    repeat (8) @(posedge clk);
    chk(ce, 1'b1);
    u_host.send(w | 16'h0020, 16);
    chk(ocw, 16'h0000);
    rp_n <= 0;
    repeat (8) @(posedge clk);
    chk({ocw[15:1], ir}, 16'h0000);
    chk(ce, 1'b1);
    hwen <= 0;
    repeat (8) @(posedge clk);
    chk(ve, 1'b0);
    close_out();
  end
endmodule : output_driver_serial_ctrl_bench
